// ### rtl/cpr_pkg.sv
`default_nettype none
package cpr_pkg;
   localparam logic [15:0] VEC_LO_ADDR = 16'h0000;
   localparam logic [15:0] VEC_HI_ADDR = 16'h0001;
   localparam logic [7:0] FLAG_RESET = 8'h02;
   localparam int IE_BIT = 7;
   localparam int Z_BIT = 6;
   localparam int AC_BIT = 4;
   localparam int CY_BIT = 0;
   localparam logic [15:0] STACK_LO = 16'hFD00;
   localparam logic [15:0] STACK_HI = 16'hFEFF;
   localparam logic [15:0] STACK_EMPTY = STACK_HI + 16'h0001;
   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] ONE16 = 16'h0001;
   localparam logic [7:0] SFR_PAGE = 8'hFF;
   localparam logic [7:0] OFS_IADDR = 8'h00;
   localparam logic [7:0] OFS_FLAGS = 8'h04;
   localparam logic [7:0] OFS_STACK = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [2:0] OFS_GPR_PAGE = 3'h1;
   localparam logic [1:0] PAIR_ZERO = 2'h0;
   localparam logic [1:0] PAIR_ONE = 2'h1;
   localparam logic [1:0] PAIR_TWO = 2'h2;
   localparam logic [1:0] PAIR_THREE = 2'h3;
   typedef enum logic [4:0] {
      OP_NOP = 5'b00000, OP_ADVANCE = 5'b00001, OP_BR_IMM = 5'b00010,
      OP_BR_REG = 5'b00011, OP_PUSH_FLAGS = 5'b00100, OP_POP_FLAGS = 5'b00101,
      OP_IRQ_ACK = 5'b00110, OP_INTR_RET = 5'b00111, OP_INTR_DIS = 5'b01000,
      OP_INTR_EN = 5'b01001, OP_PUSH_BYTE = 5'b01010, OP_ADD = 5'b01011,
      OP_SUB = 5'b01100, OP_ROTL = 5'b01101, OP_ROTR = 5'b01110,
      OP_BIT_LD = 5'b01111, OP_BIT_AND = 5'b10000, OP_WR_BYTE = 5'b10001,
      OP_WR_PAIR = 5'b10010, OP_LD_SP = 5'b10011
   } cpr_op_t;
   typedef enum logic [2:0] {
      ST_VEC_LO_REQ = 3'b000, ST_VEC_LO_WAIT = 3'b001, ST_VEC_HI_REQ = 3'b010,
      ST_VEC_HI_WAIT = 3'b011, ST_RUN = 3'b100, ST_POP_WAIT = 3'b101
   } cpr_fsm_t;
   typedef struct packed {
      cpr_op_t op;
      logic [2:0] len;
      logic [2:0] idx;
      logic [15:0] data;
   } cpr_cmd_t;
   typedef struct packed {
      logic re;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cpr_mem_t;
   typedef struct packed {
      cpr_fsm_t fsm;
      logic [15:0] pc;
      logic [7:0] flags;
      logic [15:0] sp;
      logic [7:0][7:0] gpr;
      logic stackErr;
      cpr_mem_t mem;
      logic ack;
      logic [31:0] datOut;
      logic sfrHit;
      logic sfrWide;
      logic sfrAlignErr;
   } cpr_state_t;
endpackage
`default_nettype wire

// ### rtl/cpr_regs.sv
// Chosen here: the Wishbone interface to the registers and the register offsets.
`default_nettype none
module cpr_regs (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire cpr_pkg::cpr_cmd_t coreCmd,
   output logic coreBusy,
   input wire logic irqReq,
   input wire logic irqMaskOk,
   input wire logic nmiReq,
   output logic irqAccept,
   output logic [15:0] instrAddr,
   output logic [7:0] flagWord,
   output logic [15:0] stackPtr,
   input wire logic [2:0] rdByteIdx,
   input wire logic [1:0] rdPairIdx,
   output logic [7:0] rdByte,
   output logic [15:0] rdPair,
   output var cpr_pkg::cpr_mem_t memReq,
   input wire logic memRvalid,
   input wire logic [7:0] memRdata,
   input wire logic [15:0] dataAddr,
   input wire logic dataWide,
   output logic sfrHit,
   output logic sfrWide,
   output logic sfrAlignErr
);
   // ************************************************************
   // reset synchroniser and state
   // ************************************************************
   logic [1:0] rstSync;
   logic rstN;
   cpr_pkg::cpr_state_t s_reg;
   cpr_pkg::cpr_state_t s_next;

   // two-stage release of the asynchronous reset
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstN = rstSync[1];

   // ************************************************************
   // datapath helpers
   // ************************************************************
   logic run;
   cpr_pkg::cpr_op_t op;
   logic [7:0] aluA;
   logic [7:0] aluB;
   logic [8:0] sum9;
   logic [8:0] diff9;
   logic [4:0] halfSum;
   logic [7:0] aluRes;
   logic aluWr;
   logic pairWr;
   logic pushOk;
   logic popOk;
   logic spLoadOk;
   logic busReq;
   logic busWr;
   logic busRdy;
   logic [15:0] busSp;
   logic busSpOk;
   logic [7:0][7:0] gprNext;

   assign run = (s_reg.fsm == cpr_pkg::ST_RUN);
   assign op = coreCmd.op;
   assign aluA = s_reg.gpr[coreCmd.idx];
   assign aluB = coreCmd.data[7:0];
   assign sum9 = {1'b0, aluA} + {1'b0, aluB};
   assign diff9 = {1'b0, aluA} - {1'b0, aluB};
   assign halfSum = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]};

   // alu result selection
   always_comb begin
      case (op)
         cpr_pkg::OP_ADD: aluRes = sum9[7:0];
         cpr_pkg::OP_SUB: aluRes = diff9[7:0];
         cpr_pkg::OP_ROTL: aluRes = {aluA[6:0], aluA[7]};
         cpr_pkg::OP_ROTR: aluRes = {aluA[0], aluA[7:1]};
         cpr_pkg::OP_WR_BYTE: aluRes = aluB;
         default: aluRes = aluA;
      endcase
   end

   assign aluWr = run & ((op == cpr_pkg::OP_ADD) | (op == cpr_pkg::OP_SUB)
                  | (op == cpr_pkg::OP_ROTL) | (op == cpr_pkg::OP_ROTR)
                  | (op == cpr_pkg::OP_WR_BYTE));
   assign pairWr = run & (op == cpr_pkg::OP_WR_PAIR);

   assign pushOk = (s_reg.sp > cpr_pkg::STACK_LO) & (s_reg.sp <= cpr_pkg::STACK_EMPTY);
   assign popOk = (s_reg.sp >= cpr_pkg::STACK_LO) & (s_reg.sp <= cpr_pkg::STACK_HI);
   assign spLoadOk = (coreCmd.data >= cpr_pkg::STACK_LO)
                     & (coreCmd.data <= cpr_pkg::STACK_EMPTY);

   // bus request decode
   assign busReq = wb_cyc_i & wb_stb_i;
   assign busWr = busReq & wb_we_i & s_reg.ack;
   assign busRdy = busReq & ~s_reg.ack;
   assign busSp = {wb_sel_i[1] ? wb_dat_i[15:8] : s_reg.sp[15:8],
                   wb_sel_i[0] ? wb_dat_i[7:0] : s_reg.sp[7:0]};
   assign busSpOk = (busSp >= cpr_pkg::STACK_LO) & (busSp <= cpr_pkg::STACK_EMPTY);

   // ************************************************************
   // general registers
   // ************************************************************
   // byte and pair writes per entry
   for (genvar i = 0; i < 8; i++) begin : g_gpr
      logic hitByte;
      logic hitPair;
      logic hitBus;
      assign hitByte = aluWr & (coreCmd.idx == 3'(i));
      assign hitPair = pairWr & (coreCmd.idx[1:0] == 2'(i / 2));
      assign hitBus = busWr & (wb_adr_i[7:5] == cpr_pkg::OFS_GPR_PAGE)
                      & (wb_adr_i[4:2] == 3'(i)) & wb_sel_i[0];
      assign gprNext[i] = hitBus ? wb_dat_i[7:0]
                        : hitPair ? ((i % 2) == 1 ? coreCmd.data[15:8] : coreCmd.data[7:0])
                        : hitByte ? aluRes
                        : s_reg.gpr[i];
   end

   // ************************************************************
   // next-state logic
   // ************************************************************
   // sequencer, flags, stack and bus slave
   always_comb begin
      logic setErr;
      logic clrErr;
      setErr = 1'b0;
      clrErr = 1'b0;
      s_next = s_reg;
      s_next.mem.re = 1'b0;
      s_next.mem.we = 1'b0;
      s_next.ack = 1'b0;
      s_next.gpr = gprNext;
      case (s_reg.fsm)
         cpr_pkg::ST_VEC_LO_REQ: begin
            s_next.mem.re = 1'b1;
            s_next.mem.addr = cpr_pkg::VEC_LO_ADDR;
            s_next.fsm = cpr_pkg::ST_VEC_LO_WAIT;
         end
         cpr_pkg::ST_VEC_LO_WAIT: begin
            if (memRvalid) begin
               s_next.pc[7:0] = memRdata;
               s_next.fsm = cpr_pkg::ST_VEC_HI_REQ;
            end
         end
         cpr_pkg::ST_VEC_HI_REQ: begin
            s_next.mem.re = 1'b1;
            s_next.mem.addr = cpr_pkg::VEC_HI_ADDR;
            s_next.fsm = cpr_pkg::ST_VEC_HI_WAIT;
         end
         cpr_pkg::ST_VEC_HI_WAIT: begin
            if (memRvalid) begin
               s_next.pc[15:8] = memRdata;
               s_next.fsm = cpr_pkg::ST_RUN;
            end
         end
         cpr_pkg::ST_POP_WAIT: begin
            if (memRvalid) begin
               s_next.flags = memRdata;
               s_next.sp = s_reg.sp + cpr_pkg::ONE16;
               s_next.fsm = cpr_pkg::ST_RUN;
            end
         end
         cpr_pkg::ST_RUN: begin
            case (op)
               cpr_pkg::OP_ADVANCE: s_next.pc = s_reg.pc + {13'h0000, coreCmd.len};
               cpr_pkg::OP_BR_IMM: s_next.pc = coreCmd.data;
               cpr_pkg::OP_BR_REG: begin
                  s_next.pc = {s_reg.gpr[{coreCmd.idx[1:0], 1'b1}],
                               s_reg.gpr[{coreCmd.idx[1:0], 1'b0}]};
               end
               cpr_pkg::OP_PUSH_FLAGS, cpr_pkg::OP_IRQ_ACK, cpr_pkg::OP_PUSH_BYTE: begin
                  if (op == cpr_pkg::OP_IRQ_ACK) begin
                     s_next.flags[cpr_pkg::IE_BIT] = 1'b0;
                  end
                  if (pushOk) begin
                     s_next.sp = s_reg.sp - cpr_pkg::ONE16;
                     s_next.mem.we = 1'b1;
                     s_next.mem.addr = s_reg.sp - cpr_pkg::ONE16;
                     s_next.mem.wdata = (op == cpr_pkg::OP_PUSH_BYTE) ? aluB : s_reg.flags;
                  end else begin
                     setErr = 1'b1;
                  end
               end
               cpr_pkg::OP_POP_FLAGS, cpr_pkg::OP_INTR_RET: begin
                  if (popOk) begin
                     s_next.mem.re = 1'b1;
                     s_next.mem.addr = s_reg.sp;
                     s_next.fsm = cpr_pkg::ST_POP_WAIT;
                  end else begin
                     setErr = 1'b1;
                  end
               end
               cpr_pkg::OP_INTR_DIS: s_next.flags[cpr_pkg::IE_BIT] = 1'b0;
               cpr_pkg::OP_INTR_EN: s_next.flags[cpr_pkg::IE_BIT] = 1'b1;
               cpr_pkg::OP_ADD: begin
                  s_next.flags[cpr_pkg::Z_BIT] = (sum9[7:0] == 8'h00);
                  s_next.flags[cpr_pkg::AC_BIT] = halfSum[4];
                  s_next.flags[cpr_pkg::CY_BIT] = sum9[8];
               end
               cpr_pkg::OP_SUB: begin
                  s_next.flags[cpr_pkg::Z_BIT] = (diff9[7:0] == 8'h00);
                  s_next.flags[cpr_pkg::AC_BIT] = (aluA[3:0] < aluB[3:0]);
                  s_next.flags[cpr_pkg::CY_BIT] = diff9[8];
               end
               cpr_pkg::OP_ROTL: s_next.flags[cpr_pkg::CY_BIT] = aluA[7];
               cpr_pkg::OP_ROTR: s_next.flags[cpr_pkg::CY_BIT] = aluA[0];
               cpr_pkg::OP_BIT_LD: s_next.flags[cpr_pkg::CY_BIT] = coreCmd.data[0];
               cpr_pkg::OP_BIT_AND: begin
                  s_next.flags[cpr_pkg::CY_BIT] = s_reg.flags[cpr_pkg::CY_BIT]
                                                 & coreCmd.data[0];
               end
               cpr_pkg::OP_LD_SP: begin
                  if (spLoadOk) begin
                     s_next.sp = coreCmd.data;
                  end else begin
                     setErr = 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
         default: s_next.fsm = cpr_pkg::ST_VEC_LO_REQ;
      endcase
      // bus read capture, registered on the same edge as ack
      s_next.ack = busRdy;
      if (busRdy) begin
         case (wb_adr_i)
            cpr_pkg::OFS_IADDR: s_next.datOut = {16'h0000, s_reg.pc};
            cpr_pkg::OFS_FLAGS: s_next.datOut = {24'h00_0000, s_reg.flags};
            cpr_pkg::OFS_STACK: s_next.datOut = {16'h0000, s_reg.sp};
            cpr_pkg::OFS_STATUS: s_next.datOut = {30'h0000_0000, s_reg.stackErr, ~run};
            default: begin
               if (wb_adr_i[7:5] == cpr_pkg::OFS_GPR_PAGE) begin
                  s_next.datOut = {24'h00_0000, s_reg.gpr[wb_adr_i[4:2]]};
               end else begin
                  s_next.datOut = 32'h0000_0000;
               end
            end
         endcase
      end
      // bus writes land on the edge after ack rises, while ack is high
      if (busWr) begin
         case (wb_adr_i)
            cpr_pkg::OFS_IADDR: begin
               if (wb_sel_i[0]) s_next.pc[7:0] = wb_dat_i[7:0];
               if (wb_sel_i[1]) s_next.pc[15:8] = wb_dat_i[15:8];
            end
            cpr_pkg::OFS_FLAGS: begin
               if (wb_sel_i[0]) s_next.flags = wb_dat_i[7:0];
            end
            cpr_pkg::OFS_STACK: begin
               if (busSpOk) begin
                  s_next.sp = busSp;
               end else begin
                  setErr = 1'b1;
               end
            end
            cpr_pkg::OFS_STATUS: clrErr = wb_sel_i[0] & wb_dat_i[1];
            default: begin
            end
         endcase
      end
      // sticky error, set wins over clear
      s_next.stackErr = (s_reg.stackErr & ~clrErr) | setErr;
      s_next.sfrHit = (dataAddr[15:8] == cpr_pkg::SFR_PAGE);
      s_next.sfrWide = s_next.sfrHit & dataWide;
      s_next.sfrAlignErr = s_next.sfrHit & dataWide & dataAddr[0];
   end

   // state register
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         s_reg <= '0;
         s_reg.fsm <= cpr_pkg::ST_VEC_LO_REQ;
         s_reg.pc <= cpr_pkg::PC_RESET;
         s_reg.flags <= cpr_pkg::FLAG_RESET;
         s_reg.sp <= cpr_pkg::SP_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // interrupt gating
   assign irqAccept = run & (nmiReq
                      | (irqReq & irqMaskOk & s_reg.flags[cpr_pkg::IE_BIT]));
   assign coreBusy = ~run;
   assign wb_dat_o = s_reg.datOut;
   assign wb_ack_o = s_reg.ack;
   assign instrAddr = s_reg.pc;
   assign flagWord = s_reg.flags;
   assign stackPtr = s_reg.sp;
   assign rdByte = s_reg.gpr[rdByteIdx];
   assign rdPair = {s_reg.gpr[{rdPairIdx, 1'b1}], s_reg.gpr[{rdPairIdx, 1'b0}]};
   assign memReq = s_reg.mem;
   assign sfrHit = s_reg.sfrHit;
   assign sfrWide = s_reg.sfrWide;
   assign sfrAlignErr = s_reg.sfrAlignErr;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstN);

   a_pc_advance: assert property (
      run && op == cpr_pkg::OP_ADVANCE && !busWr
      |=> instrAddr == $past(instrAddr) + {13'h0000, $past(coreCmd.len)})
      else $error("pc did not advance by length");
   a_branch_imm: assert property (
      run && op == cpr_pkg::OP_BR_IMM && !busWr |=> instrAddr == $past(coreCmd.data))
      else $error("branch target not loaded");
   a_vector_hi: assert property (
      s_reg.fsm == cpr_pkg::ST_VEC_HI_WAIT && memRvalid
      |=> instrAddr[15:8] == $past(memRdata) && coreBusy == 1'b0)
      else $error("vector high byte wrong");
   a_vector_seq: assert property (
      $rose(rstN) |-> ##1 memReq.re && memReq.addr == cpr_pkg::VEC_LO_ADDR)
      else $error("reset vector fetch missing");
   a_reset_flags: assert property (
      $rose(rstN) |-> flagWord == cpr_pkg::FLAG_RESET)
      else $error("flag reset value wrong");
   a_irq_refuse: assert property (
      !flagWord[cpr_pkg::IE_BIT] && !nmiReq |-> !irqAccept)
      else $error("maskable irq accepted while disabled");
   a_irq_mask: assert property (
      !nmiReq && !irqMaskOk |-> !irqAccept)
      else $error("masked source accepted");
   a_irq_ack: assert property (
      run && op == cpr_pkg::OP_IRQ_ACK && pushOk && !busWr
      |=> !flagWord[cpr_pkg::IE_BIT] && memReq.we && memReq.wdata == $past(flagWord))
      else $error("interrupt ack did not save flags");
   a_zero_flag: assert property (
      run && op == cpr_pkg::OP_ADD && !busWr
      |=> flagWord[cpr_pkg::Z_BIT] == ($past(sum9[7:0]) == 8'h00))
      else $error("zero flag wrong");
   a_push_predec: assert property (
      memReq.we |-> memReq.addr == stackPtr && $past(stackPtr) == stackPtr + cpr_pkg::ONE16)
      else $error("push not pre-decremented");
   a_push_window: assert property (
      memReq.we |-> memReq.addr >= cpr_pkg::STACK_LO && memReq.addr <= cpr_pkg::STACK_HI)
      else $error("stack write outside ram");
   a_sfr_align: assert property (
      dataWide && dataAddr[0] && dataAddr[15:8] == cpr_pkg::SFR_PAGE |=> sfrAlignErr)
      else $error("odd wide sfr access not flagged");
   a_bus_ack: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   c_vector_done: cover property ($rose(rstN) ##[1:40] run);
   c_pop_flags: cover property (s_reg.fsm == cpr_pkg::ST_POP_WAIT ##[1:20] run);
   c_irq_taken: cover property (irqAccept && !nmiReq);
   c_stack_err: cover property ($rose(s_reg.stackErr));
endmodule
`default_nettype wire

// ### test/cpr_regs_tb_top.sv
`default_nettype none
// one comparison, counted, reported at once on mismatch
`define CHK(act, exp) begin checksDone++; if ((act) !== (exp)) begin mismatches++; \
   $display("[FAIL] %0t got %h expected %h", $time, act, exp); end end
module cpr_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] datI = 32'h0000_0000, datO, rd;
   logic ack, busy, irqAcc, hit, wide, alErr, mValid = 1'b0;
   logic irq = 1'b0, irqOk = 1'b0, nmi = 1'b0, dWide = 1'b0;
   cpr_pkg::cpr_cmd_t cmdIn = '0;
   cpr_pkg::cpr_mem_t mReq;
   logic [15:0] pcOut, spOut, rPair, dAddr = 16'h0000;
   logic [7:0] flags, rByte, mData = 8'h00, popByte = 8'h5A;
   logic [2:0] bIdx = 3'h0;
   logic [1:0] pIdx = 2'h0;
   logic [2:0] zac;
   int mismatches = 0, checksDone = 0, cycles = 0;
   assign zac = {flags[cpr_pkg::Z_BIT], flags[cpr_pkg::AC_BIT], flags[cpr_pkg::CY_BIT]};
   cpr_regs cpr_regs_inst (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
      .wb_ack_o(ack), .coreCmd(cmdIn), .coreBusy(busy), .irqReq(irq), .irqMaskOk(irqOk),
      .nmiReq(nmi), .irqAccept(irqAcc), .instrAddr(pcOut), .flagWord(flags),
      .stackPtr(spOut), .rdByteIdx(bIdx), .rdPairIdx(pIdx), .rdByte(rByte), .rdPair(rPair),
      .memReq(mReq), .memRvalid(mValid), .memRdata(mData), .dataAddr(dAddr),
      .dataWide(dWide), .sfrHit(hit), .sfrWide(wide), .sfrAlignErr(alErr));
   // ****************************************
   // clock, memory side, timeout
   // ****************************************
   always #4 ref_clk = ~ref_clk;
   // memory answers each read one cycle later: vector bytes, else popByte
   always @(posedge ref_clk) begin
      mValid <= mReq.re;
      mData <= (mReq.addr == 16'h0000) ? 8'h34 : (mReq.addr == 16'h0001) ? 8'h12 : popByte;
   end
   // hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         results();
      end
   end
   // ****************************************
   // access tasks
   // ****************************************
   task automatic results;
      if (mismatches == 0 && checksDone > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {cyc, stb, we, adr, datI, sel} <= {2'b11, w, a, d, 4'hF};
      do @(posedge ref_clk); while (ack !== 1'b1);
      rd = datO;
      {cyc, stb} <= 2'b00;
      @(posedge ref_clk);
   endtask
   // one core op for one edge, then sample after it lands
   task automatic op(input cpr_pkg::cpr_op_t o, input logic [2:0] l, input logic [2:0] i,
                     input logic [15:0] d);
      @(posedge ref_clk);
      cmdIn <= '{o, l, i, d};
      @(posedge ref_clk);
      cmdIn <= '{cpr_pkg::OP_NOP, 3'h0, 3'h0, 16'h0000};
      #1;
   endtask
   task automatic waitIdle;
      for (int n = 0; n < 50 && busy !== 1'b0; n++) @(posedge ref_clk);
      #1;
   endtask
   task automatic sfr(input logic [15:0] a, input logic w, input logic [2:0] e);
      @(posedge ref_clk);
      {dAddr, dWide} <= {a, w};
      @(posedge ref_clk);
      #1;
      `CHK({hit, wide, alErr}, e)
   endtask
   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (16) @(posedge ref_clk);
      #1;
      `CHK({flags, busy}, {8'h02, 1'b1})
      @(posedge ref_clk);
      nrst <= 1'b1;
      waitIdle();
      `CHK(pcOut, 16'h1234)
      op(cpr_pkg::OP_ADVANCE, 3'h3, 3'h0, 16'h0000);
      `CHK(pcOut, 16'h1237)
      op(cpr_pkg::OP_BR_IMM, 3'h0, 3'h0, 16'hC0DE);
      `CHK(pcOut, 16'hC0DE)
      // byte writes, read back as pairs
      for (int p = 0; p < 4; p++) begin
         op(cpr_pkg::OP_WR_BYTE, 3'h0, 3'(2 * p), {8'h00, 8'(8'h10 + p)});
         op(cpr_pkg::OP_WR_BYTE, 3'h0, 3'(2 * p + 1), {8'h00, 8'(8'hA0 + p)});
         @(posedge ref_clk);
         pIdx <= 2'(p);
         #1;
         `CHK(rPair, {8'(8'hA0 + p), 8'(8'h10 + p)})
      end
      op(cpr_pkg::OP_BR_REG, 3'h0, 3'h1, 16'h0000);
      `CHK(pcOut, 16'hA111)
      op(cpr_pkg::OP_WR_PAIR, 3'h0, 3'h3, 16'hBEEF);
      @(posedge ref_clk);
      bIdx <= 3'h7;
      #1;
      `CHK(rByte, 8'hBE)
      // arithmetic flags on byte register 0
      @(posedge ref_clk);
      bIdx <= 3'h0;
      op(cpr_pkg::OP_WR_BYTE, 3'h0, 3'h0, 16'h000F);
      op(cpr_pkg::OP_ADD, 3'h0, 3'h0, 16'h0001);
      `CHK({rByte, zac}, {8'h10, 3'b010})
      op(cpr_pkg::OP_WR_BYTE, 3'h0, 3'h0, 16'h00FF);
      op(cpr_pkg::OP_ADD, 3'h0, 3'h0, 16'h0001);
      `CHK({rByte, zac}, {8'h00, 3'b111})
      op(cpr_pkg::OP_SUB, 3'h0, 3'h0, 16'h0001);
      `CHK({rByte, zac}, {8'hFF, 3'b011})
      op(cpr_pkg::OP_SUB, 3'h0, 3'h0, 16'h000F);
      `CHK({rByte, zac}, {8'hF0, 3'b000})
      op(cpr_pkg::OP_WR_BYTE, 3'h0, 3'h0, 16'h0080);
      op(cpr_pkg::OP_ROTL, 3'h0, 3'h0, 16'h0000);
      `CHK({rByte, zac}, {8'h01, 3'b001})
      op(cpr_pkg::OP_ROTR, 3'h0, 3'h0, 16'h0000);
      `CHK({rByte, zac}, {8'h80, 3'b001})
      op(cpr_pkg::OP_ROTR, 3'h0, 3'h0, 16'h0000);
      `CHK({rByte, zac}, {8'h40, 3'b000})
      op(cpr_pkg::OP_BIT_LD, 3'h0, 3'h0, 16'h0001);
      `CHK(zac[0], 1'b1)
      op(cpr_pkg::OP_BIT_AND, 3'h0, 3'h0, 16'h0000);
      `CHK(zac[0], 1'b0)
      // interrupt gating
      @(posedge ref_clk);
      irq <= 1'b1;
      op(cpr_pkg::OP_INTR_EN, 3'h0, 3'h0, 16'h0000);
      `CHK({flags[cpr_pkg::IE_BIT], irqAcc}, 2'b10)
      @(posedge ref_clk);
      irqOk <= 1'b1;
      #1;
      `CHK(irqAcc, 1'b1)
      op(cpr_pkg::OP_INTR_DIS, 3'h0, 3'h0, 16'h0000);
      `CHK(irqAcc, 1'b0)
      @(posedge ref_clk);
      nmi <= 1'b1;
      #1;
      `CHK(irqAcc, 1'b1)
      // stack: empty-pointer load, empty-stack push, acknowledge push, pop
      op(cpr_pkg::OP_LD_SP, 3'h0, 3'h0, 16'hFF00);
      op(cpr_pkg::OP_PUSH_FLAGS, 3'h0, 3'h0, 16'h0000);
      `CHK({spOut, mReq.we, mReq.addr, mReq.wdata}, {16'hFEFF, 1'b1, 16'hFEFF, 8'h02})
      op(cpr_pkg::OP_INTR_EN, 3'h0, 3'h0, 16'h0000);
      op(cpr_pkg::OP_IRQ_ACK, 3'h0, 3'h0, 16'h0000);
      `CHK({spOut, mReq.we, mReq.wdata[7], flags[7]}, {16'hFEFE, 3'b110})
      op(cpr_pkg::OP_POP_FLAGS, 3'h0, 3'h0, 16'h0000);
      `CHK({busy, mReq.re, mReq.addr}, {2'b11, 16'hFEFE})
      waitIdle();
      `CHK({flags, spOut}, {popByte, 16'hFEFF})
      // byte push, then interrupt return restores flags
      op(cpr_pkg::OP_PUSH_BYTE, 3'h0, 3'h0, 16'h003C);
      `CHK({spOut, mReq.we, mReq.addr, mReq.wdata}, {16'hFEFE, 1'b1, 16'hFEFE, 8'h3C})
      popByte <= 8'hA5;
      op(cpr_pkg::OP_INTR_RET, 3'h0, 3'h0, 16'h0000);
      waitIdle();
      `CHK({flags, spOut}, {8'hA5, 16'hFEFF})
      op(cpr_pkg::OP_LD_SP, 3'h0, 3'h0, 16'hFC00);
      `CHK(spOut, 16'hFEFF)
      wb(1'b0, 8'h0C, 32'h0000_0000);
      `CHK(rd[1], 1'b1)
      // error clear by write one, then a bus stack load
      wb(1'b1, 8'h0C, 32'h0000_0002);
      wb(1'b0, 8'h0C, 32'h0000_0000);
      `CHK(rd[1:0], 2'b00)
      wb(1'b1, 8'h08, 32'h0000_FD80);
      wb(1'b0, 8'h08, 32'h0000_0000);
      `CHK(rd[15:0], 16'hFD80)
      // register bus
      wb(1'b1, 8'h00, 32'h0000_4321);
      wb(1'b0, 8'h00, 32'h0000_0000);
      `CHK(rd[15:0], 16'h4321)
      wb(1'b1, 8'h24, 32'h0000_0077);
      wb(1'b0, 8'hF0, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      @(posedge ref_clk);
      bIdx <= 3'h1;
      #1;
      `CHK(rByte, 8'h77)
      sfr(16'hFF10, 1'b0, 3'b100);
      sfr(16'hFF11, 1'b1, 3'b111);
      sfr(16'hFF12, 1'b1, 3'b110);
      sfr(16'hFEFF, 1'b0, 3'b000);
      results();
   end
endmodule
`default_nettype wire
